// ### rtl/strap_and_pad_mode_control.sv
// Strap sampling, mode decode and UART pad type control
`timescale 1ns/1ps
`include "strap_pad_consts.svh"
module strap_and_pad_mode_control
   import strap_pad_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Strap pins
   input wire logic test_select_strap_b,
   input wire logic boot_select_strap,
   output logic test_strap_pull_up,
   output logic boot_strap_pull_down,
   output logic strap_input_enable,
   // Slow clock crystal detect
   input wire logic slow_clock_in,
   // Clear-to-send pad
   input wire logic clear_to_send_b,
   output logic cts_input_enable,
   output logic cts_pull_down,
   // Wake request pads
   input wire logic wake_request_in_b,
   output logic wake_in_input_enable,
   input wire logic wake_out_level_b,
   output logic wake_request_out_b,
   output logic wake_out_oe,
   output logic wake_out_input_enable,
   // Status to the core
   output logic [1:0] operating_mode,
   output logic mode_valid,
   output logic test_uart_required,
   output logic slow_xtal_present,
   output logic clear_to_send_sync_b,
   output logic wake_request_in_sync_b
);
   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   // Asserts at once, releases only on a clock edge
   logic rst_meta_reg;
   logic rst_n;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [3:0] pins_sync;
   strap_sync u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .pin_in({slow_clock_in, wake_request_in_b, clear_to_send_b,
               1'b0}),
      .pin_out(pins_sync)
   );
   // Lane 0 is spare; the other three carry async pins
   logic cts_sync_b;
   logic wake_in_sync_b;
   logic slow_sync;
   assign cts_sync_b = pins_sync[1];
   assign wake_in_sync_b = pins_sync[2];
   assign slow_sync = pins_sync[3];
   // Straps get their own pair so the pulls are on before sampling
   logic [1:0] strap_meta_reg;
   logic [1:0] strap_sync_reg;

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      boot_state_t state;
      logic [`CNT_W-1:0] count;
      logic [7:0] edges;
      logic slow_prev;
      op_mode_t mode;
      logic done;
      logic xtal;
      logic link_power;
      logic wr_pend;
      logic [7:0] addr;
      logic [31:0] rdata;
   } state_t;
   state_t cur_reg;
   state_t cur_next;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         strap_meta_reg <= 2'b00;
         strap_sync_reg <= 2'b00;
      end else begin
         strap_meta_reg <= {boot_select_strap, test_select_strap_b};
         strap_sync_reg <= strap_meta_reg;
      end
   end

   logic test_asserted;
   logic boot_asserted;
   op_mode_t decoded;
   assign test_asserted = ~strap_sync_reg[0];
   assign boot_asserted = strap_sync_reg[1];

   always_comb begin
      case ({test_asserted, boot_asserted})
         2'b10: decoded = MODE_PRODUCTION_TEST;
         2'b11: decoded = MODE_DIRECT_RADIO_TEST;
         2'b01: decoded = MODE_BOOTLOADER_START;
         default: decoded = MODE_FIRMWARE_UPDATE;
      endcase
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   logic addr_phase;
   logic slow_rise;
   assign addr_phase = hsel & hready & htrans[1];
   assign slow_rise = slow_sync & ~cur_reg.slow_prev;

   // ----------------------------------------
   // Boot sequencing
   // ----------------------------------------
   logic settle_done;
   logic window_done;
   logic edge_count_full;
   assign settle_done = (cur_reg.count == `CNT_W'(`SETTLE_CYCLES));
   assign window_done = (cur_reg.count == `XTAL_WINDOW_CYCLES);
   // Saturate so a fast oscillator cannot wrap the count to zero
   assign edge_count_full = (cur_reg.edges == `EDGE_COUNT_MAX);

   // ----------------------------------------
   // Bus decode and read words
   // ----------------------------------------
   logic read_request;
   logic write_request;
   logic write_control;
   logic test_modes_done;
   logic [7:0] read_offset;
   logic [31:0] control_word;
   logic [31:0] status_word;
   logic [31:0] slow_count_word;
   assign read_request = addr_phase & ~hwrite;
   assign write_request = addr_phase & hwrite;
   // Only the low byte decodes; higher address bits alias
   assign read_offset = haddr[7:0] & `ADDR_MASK;
   // Write data follows one cycle behind its address
   assign write_control = cur_reg.wr_pend &
      (cur_reg.addr == `ADDR_CONTROL);
   assign test_modes_done = cur_reg.done & ~cur_reg.mode[1];

   always_comb begin
      control_word = 32'h0000_0000;
      control_word[`CTRL_LINK_POWER_BIT] = cur_reg.link_power;
   end

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`STAT_MODE_MSB:`STAT_MODE_LSB] = cur_reg.mode;
      status_word[`STAT_DONE_BIT] = cur_reg.done;
      status_word[`STAT_XTAL_BIT] = cur_reg.xtal;
      status_word[`STAT_SAMPLING_BIT] = (cur_reg.state == BOOT_SETTLE);
      status_word[`STAT_TEST_MODE_BIT] = test_modes_done;
   end

   always_comb begin
      slow_count_word = 32'h0000_0000;
      slow_count_word[`SLOW_COUNT_MSB:`SLOW_COUNT_LSB] = cur_reg.edges;
   end

   always_comb begin
      cur_next = cur_reg;
      cur_next.slow_prev = slow_sync;
      case (cur_reg.state)
         BOOT_SETTLE: begin
            // Pulls settle before the straps are trusted
            if (settle_done) begin
               cur_next.mode = decoded;
               cur_next.count = '0;
               cur_next.state = BOOT_XTAL;
            end else begin
               cur_next.count = cur_reg.count + 1'b1;
            end
         end
         BOOT_XTAL: begin
            // Count slow clock edges in a fixed window
            if (slow_rise && !edge_count_full) begin
               cur_next.edges = cur_reg.edges + 1'b1;
            end
            if (window_done) begin
               cur_next.xtal = (cur_reg.edges >= `XTAL_MIN_EDGES);
               cur_next.done = 1'b1;
               cur_next.state = BOOT_RUN;
            end else begin
               cur_next.count = cur_reg.count + 1'b1;
            end
         end
         BOOT_RUN: begin
            cur_next.state = BOOT_RUN;
         end
         default: cur_next.state = BOOT_SETTLE;
      endcase

      // Bus: writes land one cycle after the address phase
      cur_next.wr_pend = write_request;
      if (addr_phase) begin
         cur_next.addr = haddr[7:0];
      end
      if (write_control) begin
         cur_next.link_power = hwdata[`CTRL_LINK_POWER_BIT];
      end
      cur_next.rdata = 32'h0000_0000;
      if (read_request) begin
         case (read_offset)
            `ADDR_CONTROL: cur_next.rdata = control_word;
            `ADDR_STATUS: cur_next.rdata = status_word;
            `ADDR_SLOW_CLOCK: cur_next.rdata = slow_count_word;
            default: cur_next.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cur_reg <= '0;
      end else begin
         cur_reg <= cur_next;
      end
   end

   // ----------------------------------------
   // Bus answers
   // ----------------------------------------
   assign hrdata = cur_reg.rdata;
   // Every access completes at once, so no wait-state logic
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // ----------------------------------------
   // Strap pads
   // ----------------------------------------
   // Buffers off after sampling so open straps draw nothing
   logic sampling;
   assign sampling = (cur_reg.state == BOOT_SETTLE);
   assign test_strap_pull_up = sampling;
   assign boot_strap_pull_down = sampling;
   assign strap_input_enable = sampling;

   // ----------------------------------------
   // UART pad types
   // ----------------------------------------
   // Host must drive floating inputs; no keeper here by design
   logic lp;
   assign lp = cur_reg.link_power;
   always_comb begin
      // Input buffer stays on in both protocol states
      cts_input_enable = 1'b1;
      wake_out_input_enable = 1'b0;
      case (lp)
         1'b1: begin
            // No pull-down: a line held high would drain current
            cts_pull_down = 1'b0;
            wake_in_input_enable = 1'b1;
            wake_out_oe = 1'b1;
            wake_request_out_b = wake_out_level_b;
         end
         default: begin
            // Pull-down keeps an open line asserted
            cts_pull_down = 1'b1;
            wake_in_input_enable = 1'b0;
            wake_out_oe = 1'b0;
            wake_request_out_b = 1'b1;
         end
      endcase
   end

   // ----------------------------------------
   // Status outputs
   // ----------------------------------------
   assign operating_mode = cur_reg.mode;
   assign mode_valid = cur_reg.done;
   // Both test modes need the full four-wire UART
   assign test_uart_required = test_modes_done;
   assign slow_xtal_present = cur_reg.xtal;
   assign clear_to_send_sync_b = cts_sync_b;
   assign wake_request_in_sync_b = lp ? wake_in_sync_b : 1'b1;
endmodule

// ### rtl/strap_pad_consts.svh
// Constants for the strap and pad mode control block
`ifndef STRAP_PAD_CONSTS_SVH
`define STRAP_PAD_CONSTS_SVH
// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define ADDR_CONTROL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_SLOW_CLOCK 8'h08
`define ADDR_MASK 8'hFC
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTRL_LINK_POWER_BIT 0
`define STAT_MODE_LSB 0
`define STAT_MODE_MSB 1
`define STAT_DONE_BIT 2
`define STAT_XTAL_BIT 3
`define STAT_SAMPLING_BIT 4
`define STAT_TEST_MODE_BIT 5
`define SLOW_COUNT_LSB 0
`define SLOW_COUNT_MSB 7
// ----------------------------------------
// Timing
// ----------------------------------------
`define SETTLE_NS 2000
`define CLOCK_NS 20
`define SETTLE_CYCLES ((`SETTLE_NS + `CLOCK_NS - 1) / `CLOCK_NS)
`define XTAL_WINDOW_CYCLES 16'h1000
`define XTAL_MIN_EDGES 8'h04
`define EDGE_COUNT_MAX 8'hFF
`define CNT_W 16
`endif

// ### rtl/strap_pad_pkg.sv
// Types for the strap and pad mode control block
package strap_pad_pkg;
   typedef enum logic [1:0] {
      MODE_PRODUCTION_TEST,
      MODE_DIRECT_RADIO_TEST,
      MODE_BOOTLOADER_START,
      MODE_FIRMWARE_UPDATE
   } op_mode_t;
   typedef enum logic [1:0] {
      BOOT_SETTLE,
      BOOT_XTAL,
      BOOT_RUN
   } boot_state_t;
endpackage

// ### rtl/strap_sync.sv
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module strap_sync (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Pins
   input wire logic [3:0] pin_in,
   output logic [3:0] pin_out
);
   logic [3:0] first_reg;
   logic [3:0] second_reg;
   genvar i;
   generate
      for (i = 0; i < 4; i = i + 1) begin : g_bit
         always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               first_reg[i] <= 1'b0;
               second_reg[i] <= 1'b0;
            end else begin
               first_reg[i] <= pin_in[i];
               second_reg[i] <= first_reg[i];
            end
         end
      end
   endgenerate
   assign pin_out = second_reg;
endmodule

// ### verif/strap_fixture.sv
// Host and test fixture model on the pad side
`timescale 1ns/1ps
module strap_fixture (
   // Bench control
   input wire logic [1:0] mode_sel,
   input wire logic xtal_on,
   input wire logic wiggle,
   // Pads
   input wire logic wake_request_out_b,
   output logic test_select_strap_b,
   output logic boot_select_strap,
   output logic slow_clock_in,
   output logic clear_to_send_b,
   output logic wake_request_in_b
);
   // Wiggle flips the straps after boot
   assign test_select_strap_b = mode_sel[1] ^ wiggle;
   assign boot_select_strap = mode_sel[1] ^ mode_sel[0] ^ wiggle;
   // Floating inputs are never left open
   // Host holds clear-to-send high once boot is over
   assign clear_to_send_b = wiggle;
   assign wake_request_in_b = wake_request_out_b;
   // Shortened crystal period so the detect window sees edges
   initial begin
      slow_clock_in = 1'h0;
      forever #200 slow_clock_in = xtal_on & ~slow_clock_in;
   end
endmodule

// ### verif/strap_pad_checker.sv
// Concurrent checks on the pad and mode outputs
`timescale 1ns/1ps
module strap_pad_checker (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Strap pads
   input wire logic test_strap_pull_up,
   input wire logic boot_strap_pull_down,
   input wire logic strap_input_enable,
   // UART pads
   input wire logic cts_input_enable,
   input wire logic cts_pull_down,
   input wire logic wake_in_input_enable,
   input wire logic wake_out_level_b,
   input wire logic wake_request_out_b,
   input wire logic wake_out_oe,
   input wire logic wake_out_input_enable,
   // Status
   input wire logic [1:0] operating_mode,
   input wire logic mode_valid,
   input wire logic test_uart_required
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   a_cts_pull_mode: assert property (cts_pull_down == !wake_out_oe)
      else $error("clear-to-send pull-down does not follow link power");
   a_cts_buffer_on: assert property (cts_input_enable)
      else $error("clear-to-send input buffer switched off");
   a_wake_in_type: assert property (wake_in_input_enable == wake_out_oe
      && !wake_out_input_enable)
      else $error("wake pad input types do not follow link power");
   a_wake_out_drive: assert property (wake_out_oe
      |-> wake_request_out_b == wake_out_level_b)
      else $error("outgoing wake pad does not follow its level");
   a_strap_pulls_tied: assert property (test_strap_pull_up ==
      boot_strap_pull_down && strap_input_enable == test_strap_pull_up)
      else $error("strap pulls and buffers disagree");
   a_strap_off_run: assert property (mode_valid |-> !strap_input_enable)
      else $error("strap buffer still on after boot");
   a_mode_held: assert property (mode_valid && $past(mode_valid)
      |-> $stable(operating_mode))
      else $error("operating mode changed after boot");
   a_uart_test_mode: assert property (test_uart_required ==
      (mode_valid && !operating_mode[1]))
      else $error("uart request flag wrong for mode");
   c_boot_done: cover property ($rose(mode_valid));
   c_radio_test: cover property (mode_valid && operating_mode == 2'h1);
   c_link_on: cover property (wake_out_oe && !wake_request_out_b);
endmodule
bind strap_and_pad_mode_control strap_pad_checker i_strap_pad_checker (
   .clock, .rst_b, .test_strap_pull_up, .boot_strap_pull_down,
   .strap_input_enable, .cts_input_enable, .cts_pull_down,
   .wake_in_input_enable, .wake_out_level_b, .wake_request_out_b,
   .wake_out_oe, .wake_out_input_enable, .operating_mode, .mode_valid,
   .test_uart_required);

// ### verif/tb_strap_and_pad_mode_control.sv
// Self-checking bench for strap and pad mode control
`timescale 1ns/1ps
module tb_strap_and_pad_mode_control;
   logic clock = '0, rst_b = '0, hsel = '0, hwrite = '0, wake_lvl_b = '1;
   logic xtal_on = '0, wiggle = '0, hreadyout, pu, pd, ie, cpd, oe, wo_b;
   logic ts_b, bs, sclk, cts_b, wi_b, mv, tur, xp, cts_s, wi_s, hresp;
   logic [1:0] htrans = '0, msel = '0, om;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
   int n_mismatch = 0, check_count = 0;
   strap_and_pad_mode_control i_strap_and_pad_mode_control (.clock, .rst_b,
      .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(1'h1),
      .hrdata, .hreadyout, .hresp, .test_select_strap_b(ts_b),
      .boot_select_strap(bs), .test_strap_pull_up(pu),
      .boot_strap_pull_down(pd), .strap_input_enable(ie),
      .slow_clock_in(sclk), .clear_to_send_b(cts_b), .cts_input_enable(),
      .cts_pull_down(cpd), .wake_request_in_b(wi_b),
      .wake_in_input_enable(), .wake_out_level_b(wake_lvl_b),
      .wake_request_out_b(wo_b), .wake_out_oe(oe), .wake_out_input_enable(),
      .operating_mode(om), .mode_valid(mv), .test_uart_required(tur),
      .slow_xtal_present(xp), .clear_to_send_sync_b(cts_s),
      .wake_request_in_sync_b(wi_s));
   strap_fixture i_strap_fixture (.mode_sel(msel), .xtal_on, .wiggle,
      .wake_request_out_b(wo_b), .test_select_strap_b(ts_b),
      .boot_select_strap(bs), .slow_clock_in(sclk), .clear_to_send_b(cts_b),
      .wake_request_in_b(wi_b));
   initial forever #10 clock = ~clock;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [31:0] a, d);
      @(posedge clock);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge clock); while (hreadyout !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'h1);
      r = hrdata;
      chk(32'(hresp), 32'h0);
   endtask
   task automatic boot(input logic [1:0] m, input logic x);
      rst_b <= 1'h0;
      msel <= m;
      xtal_on <= x;
      wiggle <= 1'h0;
      repeat (16) @(posedge clock);
      chk(32'({pu, pd, ie, cpd, oe}), 32'h1E);
      rst_b <= 1'h1;
      for (int i = 0; i < 6000 && mv !== 1'h1; i++) @(posedge clock);
      chk(32'({mv, om, xp, tur, ie}), 32'({1'h1, m, x, !m[1], 1'h0}));
      xfer(1'h0, 32'h4, 32'h0);
      chk(r, {26'h0, !m[1], 1'h0, x, 1'h1, m});
      wiggle <= 1'h1;
      repeat (20) @(posedge clock);
      chk(32'(om), 32'(m));
   endtask
   task automatic results;
      $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #1200000;
      n_mismatch++;
      results;
   end
   initial begin
      for (int m = 0; m < 4; m++) begin
         boot(2'(m), 1'(m));
         $display("Test boot mode %0d done", m);
      end
      xfer(1'h1, 32'h10, 32'hFF);
      xfer(1'h0, 32'h10, 32'h0);
      chk(r, 32'h0);
      chk(32'({cpd, oe, wo_b, wi_s, cts_s}), 32'h17);
      xfer(1'h1, 32'h0, 32'h1);
      wake_lvl_b <= 1'h0;
      repeat (6) @(posedge clock);
      chk(32'({cpd, oe, wo_b, wi_s, cts_s}), 32'h09);
      xfer(1'h0, 32'h0, 32'h0);
      chk(r, 32'h1);
      xfer(1'h1, 32'h0, 32'h0);
      repeat (6) @(posedge clock);
      chk(32'({cpd, oe, wo_b, wi_s, cts_s}), 32'h17);
      $display("Test link power done");
      results;
   end
endmodule
